// ===== design/link_error_monitor.sv
// error monitor and link maintenance registers of the deserializer
//
// Contract
// - count decoding errors, 8 bits at 0x0D
// - burst of errors drops lock, freezes counter
// - clear count on lock, read, auto clear
// - PRBS test holds decode count at zero
// - error pin low when count exceeds threshold
// - in PRBS mode pin shows PRBS errors
// - error pin released whenever count is cleared outside PRBS mode
// - auto clear about 1 us after pin low
// - auto clear off at reset, bit 6 of error_clear_and_pin_control
// - no auto clear during PRBS test
// - count PRBS errors at prbs_error_count, clear on read
// - test_and_channel_control bits 1:0 gate control channels
// - reverse channel blocked 350 us after link change
// - lock output only for video link lock
// - error_clear_and_pin_control drives and reads two open-drain pins
// - hold serializer and deserializer addresses
`timescale 1ns/10ps
module link_error_monitor #(
	parameter int REV_HOLD_CYCLES = link_error_monitor_pkg::REV_HOLD_CYC
) (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	// register access from the control channel decoder
	input  wire logic       regWrite,
	input  wire logic       regRead,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	output logic [7:0]      regRdata,
	// link status from the receiver
	input  wire logic       decodeError,
	input  wire logic       errorBurst,
	input  wire logic       videoLocked,
	input  wire logic       configLinkUp,
	input  wire logic       serialActive,
	input  wire logic       prbsError,
	// control channel gates, status outputs and device addresses
	output logic            forwardChannelOk,
	output logic            reverseChannelOk,
	output logic            lockOut,
	output logic            prbsTestActive,
	output logic [7:0]      serializerAddr,
	output logic [7:0]      deserializerAddr,
	// open-drain error pin
	output logic            errPinOut,
	output logic            errPinOe,
	// open-drain general-purpose pins
	input  wire logic       pin0Pad,
	input  wire logic       pin1Pad,
	output logic            pin0Out,
	output logic            pin0Oe,
	output logic            pin1Out,
	output logic            pin1Oe
);
	localparam int AUTO_CYC = link_error_monitor_pkg::AUTO_CLR_CYC;

	// register file and state
	logic [7:0]  testCtrl;
	logic [7:0]  clrPinCtrl;
	logic [7:0]  errThreshold;
	logic [7:0]  decodeErrorCount;
	logic [7:0]  prbsErrorCount;
	logic        frozen;
	logic        videoLockedDly;
	logic        serialActiveDly;
	logic [7:0]  autoTimer;
	logic [link_error_monitor_pkg::TIMER_W-1:0] revTimer;
	logic        pin0Meta;
	logic        pin0Sync;
	logic        pin1Meta;
	logic        pin1Sync;
	logic        errAssert;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// address decode
	logic wrSer;
	logic wrDes;
	logic wrTest;
	logic wrClrPin;
	logic wrThresh;
	logic rdDec;
	logic rdPrbs;
	assign wrSer    = regWrite && hit(regAddr,
		link_error_monitor_pkg::OFS_SER_ADDR);
	assign wrDes    = regWrite && hit(regAddr,
		link_error_monitor_pkg::OFS_DES_ADDR);
	assign wrTest   = regWrite && hit(regAddr,
		link_error_monitor_pkg::OFS_TEST_CTRL);
	assign wrClrPin = regWrite && hit(regAddr,
		link_error_monitor_pkg::OFS_CLR_PIN);
	assign wrThresh = regWrite && hit(regAddr,
		link_error_monitor_pkg::OFS_ERR_THRESH);
	assign rdDec    = regRead && hit(regAddr,
		link_error_monitor_pkg::OFS_DEC_COUNT);
	assign rdPrbs   = regRead && hit(regAddr,
		link_error_monitor_pkg::OFS_PRBS_COUNT);

	// control fields
	logic prbsMode;
	logic autoClrEn;
	assign prbsMode  = testCtrl[link_error_monitor_pkg::BIT_PRBS_EN];
	assign autoClrEn = clrPinCtrl[link_error_monitor_pkg::BIT_AUTO_CLR];

	// the pin register lags the counters by one cycle, so a clear is
	// steered into next_errAssert as well; otherwise a cleared count
	// would still leave the pin low for one more cycle
	// lock rising edge and auto-clear firing
	logic lockRise;
	logic autoFire;
	logic decClear;
	assign lockRise = videoLocked && !videoLockedDly;
	assign autoFire = autoClrEn && !prbsMode && errAssert &&
		autoTimer == 8'(AUTO_CYC - 1);
	assign decClear = lockRise || rdDec || autoFire || prbsMode;

	// decode error counter: frozen after burst until relock
	sat_counter u_dec_count (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.clear    (decClear),
		.hold     (frozen || prbsMode),
		.event_in (decodeError),
		.count    (decodeErrorCount)
	);

	// PRBS error counter, cleared by reading
	sat_counter u_prbs_count (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.clear    (rdPrbs),
		.hold     (!prbsMode),
		.event_in (prbsError),
		.count    (prbsErrorCount)
	);

	// error condition selection
	logic next_errAssert;
	assign next_errAssert = prbsMode ?
		(prbsErrorCount != link_error_monitor_pkg::COUNT_ZERO) :
		(decodeErrorCount > errThreshold && !decClear);

	// writable registers
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			serializerAddr   <= link_error_monitor_pkg::RST_SER_ADDR;
			deserializerAddr <= link_error_monitor_pkg::RST_DES_ADDR;
			testCtrl         <= link_error_monitor_pkg::RST_TEST_CTRL;
			clrPinCtrl       <= link_error_monitor_pkg::RST_CLR_PIN;
			errThreshold     <= link_error_monitor_pkg::RST_ERR_THRESH;
		end else begin
			if (wrSer)
				serializerAddr <= regWdata;
			if (wrDes)
				deserializerAddr <= regWdata;
			if (wrTest)
				testCtrl <= regWdata;
			if (wrClrPin)
				clrPinCtrl <= regWdata;
			if (wrThresh)
				errThreshold <= regWdata;
		end
	end

	// lock tracking and burst freeze
	// link level is taken in reset so release shows no false start edge
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			frozen          <= 1'b0;
			videoLockedDly  <= 1'b0;
			serialActiveDly <= serialActive;
		end else begin
			videoLockedDly  <= videoLocked;
			serialActiveDly <= serialActive;
			// a burst in the relock cycle wins: the counter freezes again
			if (errorBurst)
				frozen <= 1'b1;
			else if (lockRise)
				frozen <= 1'b0;
		end
	end

	// error pin state and auto-clear delay
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			errAssert <= 1'b0;
			autoTimer <= 8'h00;
		end else begin
			errAssert <= next_errAssert;
			if (!errAssert || autoFire || prbsMode)
				autoTimer <= 8'h00;
			else
				autoTimer <= autoTimer + 8'h01;
		end
	end

	// reverse channel hold-off after link start or stop
	logic linkEdge;
	assign linkEdge = serialActive != serialActiveDly;
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			revTimer <= '0;
		else if (linkEdge)
			revTimer <= link_error_monitor_pkg::TIMER_W'(REV_HOLD_CYCLES);
		else if (revTimer != '0)
			revTimer <= revTimer - 1'b1;
	end

	// pin input synchronisers
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pin0Meta <= 1'b1;
			pin0Sync <= 1'b1;
			pin1Meta <= 1'b1;
			pin1Sync <= 1'b1;
		end else begin
			pin0Meta <= pin0Pad;
			pin0Sync <= pin0Meta;
			pin1Meta <= pin1Pad;
			pin1Sync <= pin1Meta;
		end
	end

	// channel gates and status outputs
	assign forwardChannelOk =
		testCtrl[link_error_monitor_pkg::BIT_FWD_EN];
	assign reverseChannelOk = testCtrl[link_error_monitor_pkg::BIT_REV_EN] &&
		revTimer == '0 && !linkEdge;
	assign lockOut          = videoLocked;
	assign prbsTestActive   = prbsMode;

	// open-drain drives: only ever pull low
	// Oe high pulls the pad low; the board pull-up gives the high level
	assign errPinOut = 1'b0;
	assign errPinOe  = errAssert;
	assign pin0Out   = 1'b0;
	assign pin0Oe    = !clrPinCtrl[link_error_monitor_pkg::BIT_PIN0_OUT];
	assign pin1Out   = 1'b0;
	assign pin1Oe    = !clrPinCtrl[link_error_monitor_pkg::BIT_PIN1_OUT];

	// the mux follows regAddr with no wait state; the read strobe only
	// carries the clear side effect of the two count registers
	// read data mux, pin states replace their bits
	logic [7:0] pinView;
	always_comb begin
		pinView = clrPinCtrl;
		pinView[link_error_monitor_pkg::BIT_PIN0_IN] = pin0Sync;
		pinView[link_error_monitor_pkg::BIT_PIN1_IN] = pin1Sync;
		case (regAddr)
			link_error_monitor_pkg::OFS_SER_ADDR:   regRdata = serializerAddr;
			link_error_monitor_pkg::OFS_DES_ADDR:   regRdata = deserializerAddr;
			link_error_monitor_pkg::OFS_TEST_CTRL:  regRdata = testCtrl;
			link_error_monitor_pkg::OFS_CLR_PIN:    regRdata = pinView;
			link_error_monitor_pkg::OFS_ERR_THRESH: regRdata = errThreshold;
			link_error_monitor_pkg::OFS_DEC_COUNT:  regRdata = decodeErrorCount;
			link_error_monitor_pkg::OFS_PRBS_COUNT: regRdata = prbsErrorCount;
			default:                                regRdata = 8'h00;
		endcase
	end

	// checks share the core clock and are masked during reset
	default clocking checkClk @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// decode count: counting, freezing and clearing
	AST_DEC_COUNT: assert property (
		(decodeError && !frozen && !decClear && decodeErrorCount < 8'hFE)
		|=> decodeErrorCount == $past(decodeErrorCount) + 8'h01)
		else $error("decode error not counted");
	AST_FREEZE: assert property (
		(frozen && !decClear) |=> $stable(decodeErrorCount))
		else $error("counter moved while frozen");
	AST_READ_CLEAR: assert property (
		(rdDec || lockRise) |=> decodeErrorCount == 8'h00)
		else $error("count not cleared");
	AST_PRBS_ZERO: assert property (
		prbsMode ##1 prbsMode |-> decodeErrorCount == 8'h00)
		else $error("decode count nonzero in PRBS mode");

	// error pin in both modes
	AST_THRESH: assert property (
		(!prbsMode && !decClear && decodeErrorCount > errThreshold)
		|=> errPinOe)
		else $error("error pin not asserted");
	AST_PRBS_PIN: assert property (
		(prbsMode && prbsErrorCount != 8'h00) |=> errPinOe)
		else $error("PRBS error not shown");
	AST_RELEASE: assert property (
		((rdDec || lockRise) && !prbsMode) |=> !errPinOe)
		else $error("pin held after clear");

	// automatic clearing: only when enabled, never in PRBS mode
	AST_AUTO: assert property (
		(autoClrEn && !prbsMode && $rose(errPinOe)) ##1
		(autoClrEn && !prbsMode) [*8] |-> ##[1:AUTO_CYC] !errPinOe)
		else $error("auto clear late");
	AST_AUTO_OFF: assert property (
		(!autoClrEn && !prbsMode && errPinOe && !decClear &&
		 decodeErrorCount > errThreshold) |=> errPinOe)
		else $error("pin dropped with auto clear off");
	AST_AUTO_IDLE: assert property (
		prbsMode |=> autoTimer == 8'h00)
		else $error("auto clear timer ran in PRBS mode");

	// PRBS count, channel gates, pins and addresses
	AST_PRBS_CLEAR: assert property (
		rdPrbs |=> prbsErrorCount == 8'h00)
		else $error("PRBS count not cleared");
	AST_CHAN: assert property (
		wrTest |=> forwardChannelOk ==
		$past(regWdata[link_error_monitor_pkg::BIT_FWD_EN]))
		else $error("forward channel gate not written");
	AST_REV_HOLD: assert property (
		linkEdge |=> !reverseChannelOk [*8])
		else $error("reverse channel open early");
	AST_LOCK: assert property (
		(configLinkUp && !videoLocked) |-> !lockOut)
		else $error("lock shown for config link");
	AST_PIN_DRIVE: assert property (
		wrClrPin |=> pin0Oe ==
		!$past(regWdata[link_error_monitor_pkg::BIT_PIN0_OUT]))
		else $error("pin drive not written");
	AST_ADDR: assert property (
		wrDes |=> deserializerAddr == $past(regWdata))
		else $error("address not stored");

	// main scenarios
	COV_AUTO: cover property (autoFire);
	COV_BURST: cover property (errorBurst ##[1:20] lockRise);
	COV_PRBS: cover property (prbsMode && errPinOe);
	COV_LINK: cover property (linkEdge);
	COV_SAT: cover property (decodeErrorCount == 8'hFF);
endmodule

// ===== design/link_error_monitor_pkg.sv
// constants shared by the link error monitor design
package link_error_monitor_pkg;
	// register offsets
	localparam logic [7:0] OFS_SER_ADDR   = 8'h00;
	localparam logic [7:0] OFS_DES_ADDR   = 8'h01;
	localparam logic [7:0] OFS_TEST_CTRL  = 8'h04;
	localparam logic [7:0] OFS_CLR_PIN    = 8'h06;
	localparam logic [7:0] OFS_ERR_THRESH = 8'h0C;
	localparam logic [7:0] OFS_DEC_COUNT  = 8'h0D;
	localparam logic [7:0] OFS_PRBS_COUNT = 8'h0E;
	// field positions
	localparam int BIT_FWD_EN    = 0;
	localparam int BIT_REV_EN    = 1;
	localparam int BIT_PRBS_EN   = 5;
	localparam int BIT_PIN0_IN   = 0;
	localparam int BIT_PIN0_OUT  = 1;
	localparam int BIT_PIN1_IN   = 2;
	localparam int BIT_PIN1_OUT  = 3;
	localparam int BIT_AUTO_CLR  = 6;
	// reset values and counter limits
	localparam logic [7:0] RST_SER_ADDR   = 8'h80;
	localparam logic [7:0] RST_DES_ADDR   = 8'h90;
	localparam logic [7:0] RST_TEST_CTRL  = 8'h03;
	localparam logic [7:0] RST_CLR_PIN    = 8'h0A;
	localparam logic [7:0] RST_ERR_THRESH = 8'h00;
	localparam logic [7:0] COUNT_ZERO     = 8'h00;
	localparam logic [7:0] COUNT_MAX      = 8'hFF;
	// timing
	localparam int CLK_MHZ         = 200;
	localparam int AUTO_CLR_NS     = 1000;
	localparam int AUTO_CLR_CYC    = AUTO_CLR_NS * CLK_MHZ / 1000;
	localparam int REV_HOLD_US     = 350;
	localparam int REV_HOLD_CYC    = REV_HOLD_US * CLK_MHZ;
	localparam int TIMER_W         = 17;
endpackage

// ===== design/sat_counter.sv
// saturating 8-bit event counter with synchronous clear
`timescale 1ns/10ps
module sat_counter (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       clear,
	input  wire logic       hold,
	input  wire logic       event_in,
	output logic [7:0]      count
);
	logic [7:0] next_count;

	// clear wins over hold; counting stops at full scale
	assign next_count = clear ? link_error_monitor_pkg::COUNT_ZERO :
		(hold || !event_in ||
		 count == link_error_monitor_pkg::COUNT_MAX) ? count :
		count + 8'h01;

	// count register
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			count <= link_error_monitor_pkg::COUNT_ZERO;
		else
			count <= next_count;
	end

	AST_SATURATE: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		(count == link_error_monitor_pkg::COUNT_MAX && !clear)
		|=> count == link_error_monitor_pkg::COUNT_MAX)
		else $error("counter wrapped past full scale");
endmodule

// ===== tb/link_error_monitor_tb.sv
// self-checking bench for the link error monitor
`timescale 1ns/10ps
module link_error_monitor_tb;
	localparam int HOLD = 20;
	logic       core_clk = 1'b0;
	logic       reset_n = 1'b0;
	logic       regWrite = 1'b0;
	logic       regRead = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic [7:0] regRdata, serializerAddr, deserializerAddr;
	logic       decodeError, errorBurst, prbsError, videoLocked;
	logic       configLinkUp, serialActive, forwardChannelOk;
	logic       reverseChannelOk, lockOut, prbsTestActive;
	logic       errPinOut, errPinOe, pin0Out, pin0Oe, pin1Out, pin1Oe;
	wire logic  pin0Pad, pin1Pad;
	int         errors = 0;
	int         checks_done = 0;
	// pull-ups on the open-drain pins
	assign pin0Pad = pin0Oe ? 1'b0 : 1'b1;
	assign pin1Pad = pin1Oe ? 1'b0 : 1'b1;
	always #2.5 core_clk = ~core_clk;
	link_error_monitor #(.REV_HOLD_CYCLES(HOLD)) i_dut (.core_clk,
		.reset_n, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
		.decodeError, .errorBurst, .videoLocked, .configLinkUp,
		.serialActive, .prbsError, .forwardChannelOk, .reverseChannelOk,
		.lockOut, .prbsTestActive, .serializerAddr, .deserializerAddr,
		.errPinOut, .errPinOe, .pin0Pad, .pin1Pad, .pin0Out, .pin0Oe,
		.pin1Out, .pin1Oe);
	serializer_model i_ser (.core_clk, .decodeError, .errorBurst,
		.prbsError, .videoLocked, .configLinkUp, .serialActive);
	task automatic check(input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("errors=%0d checks=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge core_clk);
		#1;
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		@(posedge core_clk);
		#1;
		regWrite = 1'b0;
	endtask
	// strobed read, compared before the taking edge
	task automatic rchk(input logic [7:0] a, exp);
		@(posedge core_clk);
		#1;
		regAddr = a;
		regRead = 1'b1;
		#1;
		check(regRdata, exp);
		@(posedge core_clk);
		#1;
		regRead = 1'b0;
	endtask
	// look at a register without the read side effect
	task automatic pk(input logic [7:0] a, exp);
		@(posedge core_clk);
		#1;
		regAddr = a;
		#1;
		check(regRdata, exp);
	endtask
	task automatic wait_oe(input logic v, input int n);
		int i;
		for (i = 0; i < n && errPinOe !== v; i++)
			cyc(1);
		if (errPinOe !== v) begin
			errors++;
			complete_run();
		end
	endtask
	task automatic t_reset;
		rchk(8'h00, 8'h80);
		rchk(8'h01, 8'h90);
		rchk(8'h04, 8'h03);
		rchk(8'h06, 8'h0F);
		rchk(8'h0C, 8'h00);
		rchk(8'h0D, 8'h00);
		rchk(8'h07, 8'h00);
		check(errPinOe, 1'b0);
		check({forwardChannelOk, reverseChannelOk}, 8'h03);
	endtask
	task automatic t_decode;
		wr(8'h0C, 8'h02);
		i_ser.errs(1'b0, 2);
		cyc(3);
		check(errPinOe, 1'b0);
		i_ser.errs(1'b0, 1);
		pk(8'h0D, 8'h03);
		cyc(2);
		check(errPinOe, 1'b1);
		check(errPinOut, 1'b0);
		rchk(8'h0D, 8'h03);
		pk(8'h0D, 8'h00);
		cyc(1);
		check(errPinOe, 1'b0);
	endtask
	task automatic t_lock;
		i_ser.errs(1'b0, 1);
		i_ser.burst();
		i_ser.errs(1'b0, 2);
		pk(8'h0D, 8'h01);
		check(lockOut, 1'b0);
		i_ser.relock();
		cyc(2);
		pk(8'h0D, 8'h00);
		check(lockOut, 1'b1);
	endtask
	task automatic t_auto;
		wr(8'h06, 8'h4A);
		wr(8'h0C, 8'h00);
		i_ser.errs(1'b0, 1);
		wait_oe(1'b1, 5);
		cyc(150);
		check(errPinOe, 1'b1);
		wait_oe(1'b0, 100);
		pk(8'h0D, 8'h00);
	endtask
	task automatic t_prbs;
		i_ser.prbsOn = 1'b1; // far side first
		wr(8'h04, 8'h23);
		check(prbsTestActive, 1'b1);
		i_ser.errs(1'b0, 2);
		pk(8'h0D, 8'h00);
		check(errPinOe, 1'b0);
		i_ser.errs(1'b1, 1);
		wait_oe(1'b1, 5);
		cyc(300);
		check(errPinOe, 1'b1);
		rchk(8'h0E, 8'h01);
		pk(8'h0E, 8'h00);
		wr(8'h04, 8'h03);
		i_ser.prbsOn = 1'b0; // far side last
		rchk(8'h0D, 8'h00);
	endtask
	task automatic t_sat;
		wr(8'h0C, 8'hFF);
		i_ser.errs(1'b0, 260);
		pk(8'h0D, 8'hFF);
		check(errPinOe, 1'b0);
		rchk(8'h0D, 8'hFF);
	endtask
	task automatic t_chan;
		wr(8'h04, 8'h00);
		check(forwardChannelOk, 1'b0);
		check(reverseChannelOk, 1'b0);
		wr(8'h04, 8'h03);
		check({forwardChannelOk, reverseChannelOk}, 8'h03);
		i_ser.toggle();
		#1;
		check(reverseChannelOk, 1'b0);
		cyc(HOLD - 1);
		check(reverseChannelOk, 1'b0);
		cyc(3);
		check(reverseChannelOk, 1'b1);
		i_ser.rate_to(100);
		i_ser.toggle(); // link start again
		#1;
		check(reverseChannelOk, 1'b0);
		i_ser.rate_to(1000);
	endtask
	task automatic t_pins;
		wr(8'h06, 8'h08);
		check({pin0Oe, pin1Oe, pin0Out}, 8'h04);
		cyc(3);
		pk(8'h06, 8'h0C);
		wr(8'h06, 8'h0A); // release before use as input
		cyc(3);
		pk(8'h06, 8'h0F);
	endtask
	task automatic t_addr;
		wr(8'h01, 8'h42); // owner device first
		i_ser.desAddr = 8'h42; // then the far copy
		check(deserializerAddr, 8'h42);
		wr(8'h00, 8'h5A);
		rchk(8'h00, 8'h5A);
		check(serializerAddr, 8'h5A);
	endtask
	// reset, scenarios, verdict
	initial begin
		repeat (20) @(posedge core_clk);
		#1;
		reset_n = 1'b1;
		t_reset();
		t_decode();
		t_lock();
		t_auto();
		t_prbs();
		t_sat();
		t_chan();
		t_pins();
		t_addr();
		complete_run();
	end
endmodule

// ===== tb/serializer_model.sv
// far-side serializer model feeding link status to the monitor
`timescale 1ns/10ps
module serializer_model (
	input  wire logic core_clk,
	output logic      decodeError,
	output logic      errorBurst,
	output logic      prbsError,
	output logic      videoLocked,
	output logic      configLinkUp,
	output logic      serialActive
);
	logic       prbsOn = 1'b0;
	logic [7:0] desAddr = 8'h90;
	int         ctrlRate = 1000;
	// quiet link: config link up, video not yet locked
	initial begin
		decodeError = 1'b0;
		errorBurst = 1'b0;
		prbsError = 1'b0;
		videoLocked = 1'b0;
		configLinkUp = 1'b1;
		serialActive = 1'b1;
	end
	// n error pulses, one every other cycle
	task automatic errs(input logic prbs, input int n);
		repeat (n) begin
			@(posedge core_clk);
			#1;
			if (prbs && prbsOn)
				prbsError = 1'b1;
			else
				decodeError = 1'b1;
			@(posedge core_clk);
			#1;
			prbsError = 1'b0;
			decodeError = 1'b0;
		end
	endtask
	// error burst drops video lock
	task automatic burst;
		@(posedge core_clk);
		#1;
		errorBurst = 1'b1;
		videoLocked = 1'b0;
		@(posedge core_clk);
		#1;
		errorBurst = 1'b0;
	endtask
	// video link locks again
	task automatic relock;
		@(posedge core_clk);
		#1;
		videoLocked = 1'b1;
	endtask
	// step the control bit rate in kbps by factors below 3.5
	task automatic rate_to(input int target);
		while (ctrlRate > target * 3)
			ctrlRate = ctrlRate / 3;
		while (ctrlRate * 3 < target)
			ctrlRate = ctrlRate * 3;
		ctrlRate = target;
	endtask
	// link start or stop, also the restart after a rough clock change
	task automatic toggle;
		@(posedge core_clk);
		#1;
		serialActive = ~serialActive;
	endtask
endmodule
